/* logic/mbw_defs.svh */
/*
 * mbw_defs.svh: constants of the fieldbus multi-write request handler.
 * Assumes nothing; included by the package, the handler, the assertions and the bench.
 */
`ifndef MBW_DEFS_SVH
`define MBW_DEFS_SVH
`define MBW_NCOIL       512
`define MBW_COIL_AW     9
`define MBW_NWORD       64
`define MBW_WORD_AW     6
`define MBW_FC_COILS    8'h0F
`define MBW_FC_WORDS    8'h10
`define MBW_FC_EVCNT    8'h0B
`define MBW_FC_RDWR     8'h17
`define MBW_FC_ERRBIT   8'h80
`define MBW_EX_FUNC     2'h1
`define MBW_EX_ADDR     2'h2
`define MBW_MAX_COILS   17'h00100
`define MBW_MAX_RD      16'h007D
`define MBW_MAX_WR      16'h0064
`define MBW_POS_FC      16'h0007
`define MBW_POS_BC      16'h000C
`define MBW_POS_BC_RW   16'h0010
`define MBW_POS_DAT     16'h000D
`define MBW_POS_DAT_RW  16'h0011
`define MBW_LEN_EXC     16'h0003
`define MBW_LEN_ECHO    16'h0006
`define MBW_LEN_RW      16'h0003
`define MBW_HDR_BYTES   16'h0006
`endif

/* logic/mbw_pkg.sv */
/*
 * mbw_pkg: types of the fieldbus multi-write request handler.
 * Assumes mbw_defs.svh is on the include path.
 */
`include "mbw_defs.svh"
package mbw_pkg;
	typedef enum logic [0:0] {
		MBW_ST_RX = 1'b0,
		MBW_ST_TX = 1'b1
	} mbw_state_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} mbw_byte_s;

	typedef logic [`MBW_NWORD-1:0][15:0] mbw_words_t;

	typedef struct packed {
		mbw_state_e             st;
		logic [15:0]            bidx;  // received byte position
		logic [15:0]            tid;
		logic [15:0]            pid;
		logic [7:0]             unit;
		logic [7:0]             fc;
		logic [15:0]            ref0;  // first reference (read ref for rd/wr)
		logic [15:0]            cnt0;
		logic [15:0]            wref;
		logic [15:0]            wcnt;
		logic [7:0]             hi;    // upper byte of a word in flight
		logic [1:0]             exc;   // 0 = no exception
		logic [`MBW_NCOIL-1:0]  coils;
		mbw_words_t             words;
		logic [15:0]            evc;
		logic                   rx_ready;
		mbw_byte_s              tx;
		logic [15:0]            tidx;
		logic [15:0]            tot;
	} mbw_regs_s;
endpackage

/* logic/mbw_handler.sv */
/*
 * mbw_handler: slave request handler for coil forcing, multi-word write,
 * event counter query and combined read/write over a framed byte stream.
 * Assumes the TCP stack delivers one whole request per frame (last marks
 * its final byte) and drains the response bytes with tx_ready.
 */
`timescale 1ns/100ps
`include "mbw_defs.svh"
module mbw_handler (
	input  wire logic                  clk_sys,  // system clock, 40 MHz
	input  wire logic                  reset,    // synchronous, active high
	input  wire mbw_pkg::mbw_byte_s    rx,       // request byte stream
	output logic                       rx_ready, // request byte taken
	output mbw_pkg::mbw_byte_s         tx,       // response byte stream
	input  wire logic                  tx_ready, // response byte drained
	output logic [`MBW_NCOIL-1:0]      coil_out, // process output bits
	output mbw_pkg::mbw_words_t        word_out, // process output words
	output logic [15:0]                evc_out   // event counter
);
	mbw_pkg::mbw_regs_s r;
	mbw_pkg::mbw_regs_s n;

	// range check: first plus count within limit, count nonzero
	function automatic logic in_range(input logic [15:0] first,
			input logic [15:0] count, input logic [16:0] lim);
		logic [16:0] endp;
		endp = {1'b0, first} + {1'b0, count};
		in_range = (count != 16'h0000) && (endp <= lim);
	endfunction

	// response byte at position idx
	function automatic logic [7:0] resp(input mbw_pkg::mbw_regs_s s,
			input logic [15:0] idx);
		logic [15:0] len;
		logic [15:0] off;
		logic [15:0] wa;
		logic [15:0] w;
		len = `MBW_LEN_ECHO;
		off = idx - 16'h0009;
		wa = s.ref0 + {1'b0, off[15:1]};
		w = s.words[wa[`MBW_WORD_AW-1:0]];
		resp = 8'h00;
		if (s.exc != 2'h0)
			len = `MBW_LEN_EXC;
		else if (s.fc == `MBW_FC_RDWR)
			len = `MBW_LEN_RW + {s.cnt0[14:0], 1'b0};
		unique case (idx)
			16'h0000: resp = s.tid[15:8];
			16'h0001: resp = s.tid[7:0];
			16'h0002: resp = s.pid[15:8];
			16'h0003: resp = s.pid[7:0];
			16'h0004: resp = len[15:8];
			16'h0005: resp = len[7:0];
			16'h0006: resp = s.unit;
			16'h0007: resp = (s.exc != 2'h0) ?
				(s.fc | `MBW_FC_ERRBIT) : s.fc;
			default: begin
				if (s.exc != 2'h0) begin
					resp = {6'h00, s.exc};
				end else if (s.fc == `MBW_FC_EVCNT) begin
					unique case (idx)
						16'h000A: resp = s.evc[15:8];
						16'h000B: resp = s.evc[7:0];
						default:  resp = 8'h00;
					endcase
				end else if (s.fc == `MBW_FC_RDWR) begin
					if (idx == 16'h0008)
						resp = {s.cnt0[6:0], 1'b0};
					else
						resp = off[0] ? w[7:0] : w[15:8];
				end else begin
					unique case (idx)
						16'h0008: resp = s.ref0[15:8];
						16'h0009: resp = s.ref0[7:0];
						16'h000A: resp = s.cnt0[15:8];
						default:  resp = s.cnt0[7:0];
					endcase
				end
			end
		endcase
	endfunction

	// next state: request parsing, image updates, response sequencing
	always_comb begin
		logic        rw;
		logic [15:0] di;
		logic [15:0] bit_n;
		logic [15:0] ca;
		logic [15:0] wi;
		logic [15:0] wa;
		logic        ok;
		n = r;
		rw = (r.fc == `MBW_FC_RDWR);
		di = r.bidx - (rw ? `MBW_POS_DAT_RW : `MBW_POS_DAT);
		wi = {1'b0, di[15:1]};
		wa = (rw ? r.wref : r.ref0) + wi;
		bit_n = 16'h0000;
		ca = 16'h0000;
		ok = 1'b0;
		unique case (r.st)
			mbw_pkg::MBW_ST_RX: begin
				if (rx.valid && r.rx_ready) begin
					n.bidx = r.bidx + 16'h0001;
					unique case (r.bidx)
						16'h0000: n.tid[15:8] = rx.data;
						16'h0001: n.tid[7:0] = rx.data;
						16'h0002: n.pid[15:8] = rx.data;
						16'h0003: n.pid[7:0] = rx.data;
						16'h0006: n.unit = rx.data;
						16'h0007: begin
							n.fc = rx.data;
							if (rx.data != `MBW_FC_COILS &&
									rx.data != `MBW_FC_WORDS &&
									rx.data != `MBW_FC_EVCNT &&
									rx.data != `MBW_FC_RDWR)
								n.exc = `MBW_EX_FUNC;
						end
						16'h0008: n.ref0[15:8] = rx.data;
						16'h0009: n.ref0[7:0] = rx.data;
						16'h000A: n.cnt0[15:8] = rx.data;
						16'h000B: n.cnt0[7:0] = rx.data;
						16'h000C: begin
							if (rw)
								n.wref[15:8] = rx.data;
						end
						16'h000D: begin
							if (rw)
								n.wref[7:0] = rx.data;
						end
						16'h000E: begin
							if (rw)
								n.wcnt[15:8] = rx.data;
						end
						16'h000F: begin
							if (rw)
								n.wcnt[7:0] = rx.data;
						end
						default: ;
					endcase
					// byte count arrives: all counts known, validate
					if (r.exc == 2'h0 && r.bidx == `MBW_POS_BC &&
							r.fc == `MBW_FC_COILS) begin
						ok = in_range(r.ref0, r.cnt0,
							17'(`MBW_NCOIL)) &&
							({1'b0, r.cnt0} <= `MBW_MAX_COILS);
						if (!ok)
							n.exc = `MBW_EX_ADDR;
					end
					if (r.exc == 2'h0 && r.bidx == `MBW_POS_BC &&
							r.fc == `MBW_FC_WORDS) begin
						ok = in_range(r.ref0, r.cnt0,
							17'(`MBW_NWORD)) &&
							({8'h00, rx.data} ==
							{r.cnt0[14:0], 1'b0});
						if (!ok)
							n.exc = `MBW_EX_ADDR;
					end
					if (r.exc == 2'h0 && r.bidx == `MBW_POS_BC_RW &&
							rw) begin
						ok = in_range(r.ref0, r.cnt0,
							17'(`MBW_NWORD)) &&
							(r.cnt0 <= `MBW_MAX_RD) &&
							in_range(r.wref, r.wcnt,
							17'(`MBW_NWORD)) &&
							(r.wcnt <= `MBW_MAX_WR) &&
							({8'h00, rx.data} ==
							{r.wcnt[14:0], 1'b0});
						if (!ok)
							n.exc = `MBW_EX_ADDR;
					end
					// coil data: bit i of byte k is coil ref+8k+i
					if (r.exc == 2'h0 && r.fc == `MBW_FC_COILS &&
							r.bidx >= `MBW_POS_DAT) begin
						for (int i = 0; i < 8; i++) begin
							bit_n = {di[12:0], 3'h0} + 16'(i);
							ca = r.ref0 + bit_n;
							if (bit_n < r.cnt0)
								n.coils[ca[`MBW_COIL_AW-1:0]] =
									rx.data[i];
						end
					end
					// word data: upper byte first, write on lower
					if (r.exc == 2'h0 && (r.fc == `MBW_FC_WORDS || rw) &&
							r.bidx >= (rw ? `MBW_POS_DAT_RW :
							`MBW_POS_DAT) &&
							wi < (rw ? r.wcnt : r.cnt0)) begin
						if (!di[0])
							n.hi = rx.data;
						else
							n.words[wa[`MBW_WORD_AW-1:0]] =
								{r.hi, rx.data};
					end
					if (rx.last) begin
						n.st = mbw_pkg::MBW_ST_TX;
						n.rx_ready = 1'b0;
						n.tidx = 16'h0000;
						n.tot = `MBW_HDR_BYTES + `MBW_LEN_ECHO;
						if (n.exc != 2'h0)
							n.tot = `MBW_HDR_BYTES + `MBW_LEN_EXC;
						else if (rw)
							n.tot = `MBW_HDR_BYTES + `MBW_LEN_RW +
								{r.cnt0[14:0], 1'b0};
						if (n.exc == 2'h0 && n.fc != `MBW_FC_EVCNT)
							n.evc = r.evc + 16'h0001;
					end
				end
			end
			mbw_pkg::MBW_ST_TX: begin
				if (!r.tx.valid || tx_ready) begin
					if (r.tidx == r.tot) begin
						n.tx = '0;
						n.st = mbw_pkg::MBW_ST_RX;
						n.rx_ready = 1'b1;
						n.bidx = 16'h0000;
						n.exc = 2'h0;
						n.fc = 8'h00;
					end else begin
						n.tx.valid = 1'b1;
						n.tx.data = resp(r, r.tidx);
						n.tx.last = (r.tidx == r.tot - 16'h0001);
						n.tidx = r.tidx + 16'h0001;
					end
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			r <= '0;
			r.rx_ready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state register
	assign rx_ready = r.rx_ready;
	assign tx = r.tx;
	assign coil_out = r.coils;
	assign word_out = r.words;
	assign evc_out = r.evc;
endmodule

/* dv/mbw_assertions.sv */
/* mbw_assertions: handshake, counter and reply checks of the handler.
   Bound to mbw_handler; sees its ports only. */
`timescale 1ns/100ps
`include "mbw_defs.svh"
module mbw_assertions (
	input wire logic                  clk_sys,  // clock
	input wire logic                  reset,    // sync reset
	input wire mbw_pkg::mbw_byte_s    rx,       // request bytes
	input wire logic                  rx_ready, // request taken
	input wire mbw_pkg::mbw_byte_s    tx,       // reply bytes
	input wire logic                  tx_ready, // reply taken
	input wire logic [`MBW_NCOIL-1:0] coil_out, // coils
	input wire mbw_pkg::mbw_words_t   word_out, // words
	input wire logic [15:0]           evc_out   // event count
);
	logic [15:0] tpos;
	logic [7:0]  fcb;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// reply byte position and the function byte of the reply
	always_ff @(posedge clk_sys) begin
		if (reset || (tx.valid && tx_ready && tx.last))
			tpos <= 16'h0000;
		else if (tx.valid && tx_ready)
			tpos <= tpos + 16'h0001;
		if (tx.valid && tx_ready && tpos == 16'h0007)
			fcb <= tx.data;
	end
	property p_ans; rx.valid && rx_ready && rx.last |=>
		!rx_ready ##1 tx.valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_busy; tx.valid |-> !rx_ready; endproperty
	a_busy: assert property (p_busy) else $error("rx open");
	property p_hold; tx.valid && !tx_ready |=>
		tx.valid && $stable(tx.data) && $stable(tx.last); endproperty
	a_hold: assert property (p_hold) else $error("tx moved");
	property p_evc; $changed(evc_out) |->
		evc_out == $past(evc_out) + 16'h0001 && !$past(tx.valid); endproperty
	a_evc: assert property (p_evc) else $error("count step");
	property p_img; $changed(coil_out) || $changed(word_out) |->
		$past(rx.valid && rx_ready); endproperty
	a_img: assert property (p_img) else $error("image moved");
	property p_exc; tx.valid && tpos == 16'h0008 && fcb[7] |->
		tx.last && tx.data inside {8'h01, 8'h02}; endproperty
	a_exc: assert property (p_exc) else $error("bad code");
	property p_stat; tx.valid && fcb == 8'h0B && tpos inside {16'h0008,
		16'h0009} |-> tx.data == 8'h00; endproperty
	a_stat: assert property (p_stat) else $error("status");
	property p_end; tx.valid && tx_ready && tx.last |=>
		!tx.valid ##[0:1] rx_ready; endproperty
	a_end: assert property (p_end) else $error("no reopen");
	c_exc: cover property (tx.valid && tpos == 16'h0008 && fcb[7]);
	c_stat: cover property (tx.valid && fcb == 8'h0B);
	c_hold: cover property (tx.valid && !tx_ready);
endmodule
bind mbw_handler mbw_assertions u_chk (.clk_sys(clk_sys), .reset(reset),
	.rx(rx), .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready),
	.coil_out(coil_out), .word_out(word_out), .evc_out(evc_out));

/* dv/mbw_master_model.sv */
/* mbw_master_model: remote master; sends a frame from q, drains reply to r.
   Called through xfer() by the bench; pins change at falling edges. */
`timescale 1ns/100ps
module mbw_master_model (
	input wire logic               clk_sys,  // clock
	input wire logic               slow,     // stall the drain
	output mbw_pkg::mbw_byte_s     rx,       // request bytes
	input wire logic               rx_ready, // byte taken
	input wire mbw_pkg::mbw_byte_s tx,       // reply bytes
	output logic                   tx_ready, // reply drain
	output int                     err       // hang count
);
	logic [7:0] q[$];
	logic [7:0] r[$];
	int         n;
	// idle pins
	initial begin
		rx = '0;
		tx_ready = 1'b0;
		err = 0;
	end
	// one frame held until taken, then the whole reply
	task automatic xfer();
		bit g;
		bit done;
		r = {};
		foreach (q[i]) begin
			@(negedge clk_sys);
			rx <= {1'b1, q[i], i == q.size() - 1};
			n = 0;
			while (!rx_ready && n < 99) begin
				@(negedge clk_sys);
				n++;
			end
			if (!rx_ready)
				err++;
			@(posedge clk_sys);
		end
		@(negedge clk_sys);
		rx <= {1'b0, ~q[$], 1'b0};
		n = 0;
		done = 1'b0;
		do begin
			@(negedge clk_sys);
			g = !slow || n % 3 != 0;
			tx_ready <= g;
			if (tx.valid && g)
				r.push_back(tx.data);
			done = tx.valid && g && tx.last;
			n++;
		end while (!done && n < 999);
		if (!done)
			err++;
		@(negedge clk_sys);
		tx_ready <= 1'b0;
	endtask
endmodule

/* dv/mbw_handler_tb.sv */
/* mbw_handler_tb: request frames through the master model; each reply
   and the image are compared with a bench model. Needs the model file. */
`timescale 1ns/100ps
`include "mbw_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error %0t got %0h exp %0h", $time, a, b); end end
module mbw_handler_tb;
	logic                  clk_sys, reset, slow, rx_ready, tx_ready;
	mbw_pkg::mbw_byte_s    rx, tx;
	logic [`MBW_NCOIL-1:0] coil_out, c_m;
	mbw_pkg::mbw_words_t   word_out, w_m;
	logic [15:0]           evc_out, e_m;
	logic [7:0]            e[$];
	int                    n_mismatch, n_tests, err, seed = 65;
	// design and remote master
	mbw_handler DUT (.clk_sys(clk_sys), .reset(reset), .rx(rx),
		.rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready),
		.coil_out(coil_out), .word_out(word_out), .evc_out(evc_out));
	mbw_master_model M (.clk_sys(clk_sys), .slow(slow), .rx(rx),
		.rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready), .err(err));
	// clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// verdict
	task automatic close_out();
		$display("mismatches %0d tests %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one request, bench model update and full comparison
	task automatic run(input logic [7:0] fc, input int rf, n, wr, wn, bc);
		logic [15:0] t;
		logic [7:0]  d[$], p[$];
		logic        ok;
		t = 16'($random(seed));
		M.q = {t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, fc};
		if (fc != 8'h0B) begin
			M.q = {M.q, rf[15:8], rf[7:0], n[15:8], n[7:0]};
			if (fc == 8'h17)
				M.q = {M.q, wr[15:8], wr[7:0], wn[15:8], wn[7:0]};
			repeat (bc) d.push_back(8'($random(seed)));
			M.q = {M.q, 8'(bc), d};
		end
		case (fc)
		8'h0F: ok = n > 0 && n <= 256 && rf + n <= 512;
		8'h10: ok = n > 0 && rf + n <= 64 && bc == 2 * n;
		8'h17: ok = n > 0 && n <= 125 && wn > 0 && wn <= 100 &&
			rf + n <= 64 && wr + wn <= 64 && bc == 2 * wn;
		8'h0B: ok = 1'b1;
		default: ok = 1'b0;
		endcase
		if (!ok)
			p = {fc | 8'h80, fc inside {8'h0F, 8'h10, 8'h17} ? 8'h02 : 8'h01};
		else if (fc == 8'h0B)
			p = {fc, 8'h00, 8'h00, e_m[15:8], e_m[7:0]};
		else if (fc == 8'h17) begin
			for (int i = 0; i < wn; i++)
				w_m[wr + i] = {d[2 * i], d[2 * i + 1]};
			p = {fc, 8'(2 * n)};
			for (int i = 0; i < n; i++)
				p = {p, w_m[rf + i][15:8], w_m[rf + i][7:0]};
		end else begin
			for (int i = 0; i < n; i++)
				if (fc == 8'h0F)
					c_m[rf + i] = d[i / 8][i % 8];
				else
					w_m[rf + i] = {d[2 * i], d[2 * i + 1]};
			p = {fc, rf[15:8], rf[7:0], n[15:8], n[7:0]};
		end
		if (ok && fc != 8'h0B)
			e_m++;
		e = {t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'(p.size() + 1), 8'h01, p};
		M.xfer();
		if (err != 0) begin
			n_mismatch++;
			close_out();
		end
		`CHK(M.r.size(), e.size())
		foreach (e[i]) `CHK(M.r[i], e[i])
		`CHK(coil_out, c_m)
		`CHK(word_out, w_m)
		`CHK(evc_out, e_m)
	endtask
	// scenarios
	initial begin
		reset = 1'b1;
		slow = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		c_m = '0;
		w_m = '0;
		e_m = 16'h0000;
		repeat (6) @(negedge clk_sys);
		reset = 1'b0;
		run(8'h0B, 0, 0, 0, 0, 0);
		run(8'h0F, 0, 16, 0, 0, 2);
		slow = 1'b1;
		run(8'h0F, 256, 256, 0, 0, 32);
		run(8'h0F, 3, 257, 0, 0, 33);
		run(8'h0F, 511, 2, 0, 0, 1);
		run(8'h10, 62, 2, 0, 0, 4);
		run(8'h10, 63, 2, 0, 0, 4);
		run(8'h10, 5, 2, 0, 0, 3);
		slow = 1'b0;
		run(8'h17, 0, 2, 3, 1, 2);
		run(8'h17, 10, 54, 0, 10, 20);
		run(8'h17, 0, 126, 9, 1, 2);
		run(8'h17, 0, 1, 9, 101, 202);
		run(8'h17, 0, 1, 9, 2, 3);
		run(8'h03, 0, 1, 0, 0, 0);
		for (int k = 0; k < 6; k++)
			run(8'h10, $unsigned($random(seed)) % 56, 8, 0, 0, 16);
		run(8'h0B, 0, 0, 0, 0, 0);
		close_out();
	end
endmodule
